// file: core/sccs_div4.sv
// Purpose: Divides a stream of system clock ticks by four onto a level.
// Assumes: tick_in is a one-cycle pulse per system clock period.
// Notes: Held low while run is low, so the pin starts on a full period.
`timescale 1ns/100ps
module sccs_div4
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic tick_in,
   input wire logic run,
   output logic clk_out
);
   import sccs_pkg::*;

   // All state of this divider.
   typedef struct packed {
      logic [1:0] cnt;
   } sccs_div_t;

   sccs_div_t q; // Registered state.
   sccs_div_t n; // Next state.

   // Two ticks high, two ticks low gives a quarter of the tick rate.
   always_comb
   begin
      n = q;
      if (!run)
      begin
         n.cnt = 2'h0;
      end
      else if (tick_in)
      begin
         n.cnt = q.cnt + 2'h1;
      end
   end

   // State register.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         q <= '0;
      end
      else
      begin
         q <= n;
      end
   end

   assign clk_out = q.cnt[1];

endmodule : sccs_div4

// file: core/sccs_pkg.sv
// Purpose: Shared constants and types of the system clock source select block.
// Assumes: sys_clk runs at 10 MHz; rates are modelled by phase accumulators.
// Notes: Mode codes and register offsets live here only.
package sccs_pkg;

   // Register offsets on the plain register port.
   localparam logic [3:0] REG_TUNE = 4'h0;
   localparam logic [3:0] REG_FREQ = 4'h1;
   localparam logic [3:0] REG_STAT = 4'h2;
   typedef logic [3:0] sccs_addr_t;
   typedef logic [7:0] sccs_data_t;

   // Reset values and field positions.
   localparam logic [5:0] TUNE_RESET = 6'h00;
   localparam logic [2:0] FREQ_RESET = 3'h0;
   localparam int TUNE_MSB = 5;
   localparam int FREQ_MSB = 2;

   // Oscillator modes, as held in the four-bit configuration field.
   typedef enum logic [3:0] {
      LOW_POWER_CRYSTAL_MODE = 4'h0,
      STANDARD_CRYSTAL_MODE = 4'h1,
      HIGH_SPEED_CRYSTAL_MODE = 4'h2,
      RC_CLOCK_OUT_MODE = 4'h3,
      EXT_CLOCK_OUT_MODE = 4'h4,
      EXT_CLOCK_IO_MODE = 4'h5,
      PLL_CRYSTAL_MODE = 4'h6,
      RC_IO_MODE = 4'h7,
      INTERNAL_OSC_DUAL_IO_MODE = 4'h8,
      INTERNAL_OSC_CLKOUT_MODE = 4'h9
   } sccs_mode_t;
   localparam sccs_mode_t MODE_RESET = HIGH_SPEED_CRYSTAL_MODE;

   // Control states, Gray coded along load, run, switch.
   typedef enum logic [1:0] {
      ST_LOAD = 2'h0,
      ST_RUN = 2'h1,
      ST_SWITCH = 2'h3
   } sccs_state_e_t;

   // Timing: sys_clk period and the fast source settle time.
   localparam int CLK_PERIOD_NS = 100;
   localparam int FAST_SETTLE_MS = 1;
   localparam int FAST_SETTLE_CYC = FAST_SETTLE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SLOW_SETTLE_TICKS = 8;

   // Rate model: sys_clk rate in kHz is the accumulator modulus.
   localparam logic [13:0] ACC_MOD = 14'h2710;
   localparam logic [13:0] FAST_STEP = 14'h1F40;
   localparam logic [7:0] SLOW_STEP = 8'h1F;

   // PLL figures in kHz.
   localparam logic [15:0] PLL_MAX_IN_KHZ = 16'h2710;
   localparam logic [15:0] PLL_MAX_OUT_KHZ = 16'h9C40;

   // Frequency of each internal frequency select code, in kHz.
   function automatic logic [15:0] internal_freq_select_khz(input logic [2:0] sel);
      case (sel)
         3'h7: internal_freq_select_khz = 16'h1F40;
         3'h6: internal_freq_select_khz = 16'h0FA0;
         3'h5: internal_freq_select_khz = 16'h07D0;
         3'h4: internal_freq_select_khz = 16'h03E8;
         3'h3: internal_freq_select_khz = 16'h01F4;
         3'h2: internal_freq_select_khz = 16'h00FA;
         3'h1: internal_freq_select_khz = 16'h007D;
         default: internal_freq_select_khz = 16'h001F;
      endcase
   endfunction : internal_freq_select_khz

   // Postscaler mask: divide by two to the power of seven minus the code.
   function automatic logic [5:0] post_mask(input logic [2:0] sel);
      case (sel)
         3'h6: post_mask = 6'h01;
         3'h5: post_mask = 6'h03;
         3'h4: post_mask = 6'h07;
         3'h3: post_mask = 6'h0F;
         3'h2: post_mask = 6'h1F;
         3'h1: post_mask = 6'h3F;
         default: post_mask = 6'h00;
      endcase
   endfunction : post_mask

endpackage : sccs_pkg

// file: core/sccs_top.sv
// Purpose: Selects and conditions the system clock source and oscillator pins.
// Assumes: Pins are synchronous to sys_clk; external rate given in kHz.
// Notes: Internal sources are phase accumulators giving one-cycle ticks.
// Behaviour
// - PLL crystal mode multiplies crystal by four.
// - PLL enabled only in PLL crystal mode.
// - External clock modes need no start-up delay.
// - External clock-out mode drives pin quarter rate.
// - External I/O mode frees pin as bit6.
// - RC clock-out mode drives pin quarter rate.
// - RC I/O mode frees pin as bit6.
// - Fast source with postscaler, 125 kHz-4 MHz.
// - Fast source on only for 125k-8M selections.
// - Slow source on for internal or features.
// - Frequency select field picks the source.
// - Internal clkout mode: quarter rate, bit7 I/O.
// - Internal dual mode: both pins are I/O.
// - Tuning drifts sources, bounded settle times.
// - No flag reports tuning shift completed.
// - Tune field is a signed offset.
// - Tune register: six bits, upper read zero.
// - Ten modes from four configuration bits.
// - Select codes map to frequencies.
`timescale 1ns/100ps
module sccs_top
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [3:0] osc_mode_config,
   input wire logic [15:0] ext_freq_khz,
   input wire logic pwrt_en,
   input wire logic fscm_en,
   input wire logic wdt_en,
   input wire logic two_speed_en,
   input wire sccs_pkg::sccs_addr_t reg_addr,
   input wire sccs_pkg::sccs_data_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output sccs_pkg::sccs_data_t reg_rdata,
   input wire logic osc_pin_in_i,
   output logic osc_pin_in_o,
   output logic osc_pin_in_oe_b,
   input wire logic osc_pin_out_i,
   output logic osc_pin_out_o,
   output logic osc_pin_out_oe_b,
   input wire logic port_a_bit6_o,
   input wire logic port_a_bit6_oe_b,
   output logic port_a_bit6_i,
   input wire logic port_a_bit7_o,
   input wire logic port_a_bit7_oe_b,
   output logic port_a_bit7_i,
   output logic sys_tick,
   output logic [15:0] sysclk_freq_khz,
   output logic pll_enable,
   output logic pll_range_err,
   output logic osc_startup_req,
   output logic fast_src_en,
   output logic slow_src_en
);
   import sccs_pkg::*;

   // All state of the block in one record.
   typedef struct packed {
      sccs_state_e_t st;
      sccs_mode_t mode;
      logic [5:0] tune;
      logic [2:0] internal_freq_select;
      logic [2:0] internal_freq_select_act;
      logic [13:0] fast_acc;
      logic [13:0] slow_acc;
      logic [13:0] fast_step;
      logic [7:0] slow_step;
      logic [5:0] post_cnt;
      logic pin_prev;
      logic fast_tick;
      logic slow_tick;
      logic sys_tick;
      logic range_err;
      logic [15:0] freq_khz;
      logic [7:0] rdata;
   } sccs_reg_t;

   // Reset image of the state record.
   localparam sccs_reg_t REG_INIT = '{
      st: ST_LOAD,
      mode: MODE_RESET,
      tune: TUNE_RESET,
      internal_freq_select: FREQ_RESET,
      internal_freq_select_act: FREQ_RESET,
      fast_acc: 14'h0000,
      slow_acc: 14'h0000,
      fast_step: FAST_STEP,
      slow_step: SLOW_STEP,
      post_cnt: 6'h00,
      pin_prev: 1'b0,
      fast_tick: 1'b0,
      slow_tick: 1'b0,
      sys_tick: 1'b0,
      range_err: 1'b0,
      freq_khz: 16'h0000,
      rdata: 8'h00
   };

   sccs_reg_t q; // Registered state.
   sccs_reg_t n; // Next state.

   logic is_int; // Internal block clocks the system.
   logic is_clkout; // Second pin carries a quarter-rate clock.
   logic is_io6; // Second pin is port A bit 6.
   logic is_xtal; // Crystal modes that need start-up.
   logic [13:0] fast_tgt; // Tuned step of the fast source.
   logic [7:0] slow_tgt; // Tuned step of the slow source.
   logic div_clk; // Quarter-rate clock from the divider.

   // Tick of the source chosen by a select code.
   function automatic logic src_tick(input logic [2:0] sel, input logic ft,
                                     input logic stk, input logic [5:0] cnt);
      if (sel == 3'h7)
      begin
         src_tick = ft;
      end
      else if (sel == 3'h0)
      begin
         src_tick = stk;
      end
      else
      begin
         src_tick = ft && ((cnt & post_mask(sel)) == post_mask(sel));
      end
   endfunction : src_tick

   // Mode groups decoded from the latched configuration.
   always_comb
   begin
      is_int = (q.mode == INTERNAL_OSC_CLKOUT_MODE) ||
               (q.mode == INTERNAL_OSC_DUAL_IO_MODE);
      is_clkout = (q.mode == EXT_CLOCK_OUT_MODE) ||
                  (q.mode == RC_CLOCK_OUT_MODE) ||
                  (q.mode == INTERNAL_OSC_CLKOUT_MODE);
      is_io6 = (q.mode == EXT_CLOCK_IO_MODE) ||
               (q.mode == RC_IO_MODE) ||
               (q.mode == INTERNAL_OSC_DUAL_IO_MODE);
      is_xtal = (q.mode == LOW_POWER_CRYSTAL_MODE) ||
                (q.mode == STANDARD_CRYSTAL_MODE) ||
                (q.mode == HIGH_SPEED_CRYSTAL_MODE) ||
                (q.mode == PLL_CRYSTAL_MODE);
   end

   // Tune targets: the field is two's complement around the calibrated step.
   assign fast_tgt = FAST_STEP + {{5{q.tune[5]}}, q.tune, 3'h0};
   assign slow_tgt = SLOW_STEP + {{5{q.tune[5]}}, q.tune[5:3]};

   // Source enables; the fast source also runs for a pending selection.
   assign fast_src_en = is_int && ((q.internal_freq_select_act != 3'h0) || (q.internal_freq_select != 3'h0));
   assign slow_src_en = is_int || pwrt_en || fscm_en || wdt_en || two_speed_en;

   // Next-state logic for the whole block.
   always_comb
   begin
      logic [14:0] fsum;
      logic [14:0] ssum;
      logic ext_tick;
      logic ft;
      logic stk;
      fsum = 15'h0000;
      ssum = 15'h0000;
      ext_tick = 1'b0;
      ft = 1'b0;
      stk = 1'b0;
      n = q;
      n.sys_tick = 1'b0;
      n.rdata = 8'h00;
      n.pin_prev = osc_pin_in_i;
      // A rising edge on the first pin is one period of an outside clock.
      ext_tick = osc_pin_in_i && !q.pin_prev;

      // Fast source: accumulator gives ticks at the tuned rate.
      if (fast_src_en)
      begin
         fsum = {1'b0, q.fast_acc} + {1'b0, q.fast_step};
         if (fsum >= {1'b0, ACC_MOD})
         begin
            ft = 1'b1;
            fsum = fsum - {1'b0, ACC_MOD};
         end
         n.fast_acc = fsum[13:0];
      end
      else
      begin
         n.fast_acc = 14'h0000;
      end
      if (ft)
      begin
         n.post_cnt = q.post_cnt + 6'h01;
      end

      // Slow source, same scheme with its own step.
      if (slow_src_en)
      begin
         ssum = {1'b0, q.slow_acc} + {7'h00, q.slow_step};
         if (ssum >= {1'b0, ACC_MOD})
         begin
            stk = 1'b1;
            ssum = ssum - {1'b0, ACC_MOD};
         end
         n.slow_acc = ssum[13:0];
      end
      else
      begin
         n.slow_acc = 14'h0000;
      end
      n.fast_tick = ft;
      n.slow_tick = stk;

      // Drift toward new tuning while running; no done flag exists.
      if (q.fast_step < fast_tgt)
      begin
         n.fast_step = q.fast_step + 14'h0001;
      end
      else if (q.fast_step > fast_tgt)
      begin
         n.fast_step = q.fast_step - 14'h0001;
      end
      // The slow step moves once per own tick, so it settles in a few ticks.
      if (stk && (q.slow_step < slow_tgt))
      begin
         n.slow_step = q.slow_step + 8'h01;
      end
      else if (stk && (q.slow_step > slow_tgt))
      begin
         n.slow_step = q.slow_step - 8'h01;
      end

      // Control sequence: load the mode once, then run or switch.
      case (q.st)
         ST_LOAD:
         begin
            n.mode = sccs_mode_t'(osc_mode_config);
            n.st = ST_RUN;
         end
         ST_RUN:
         begin
            if (is_int && (q.internal_freq_select != q.internal_freq_select_act))
            begin
               n.st = ST_SWITCH;
            end
            else if (is_int)
            begin
               n.sys_tick = src_tick(q.internal_freq_select_act, ft, stk, q.post_cnt);
            end
            else
            begin
               n.sys_tick = ext_tick;
            end
            if (!is_int)
            begin
               n.internal_freq_select_act = q.internal_freq_select;
            end
         end
         ST_SWITCH:
         begin
            // Output paused until the new source starts a whole period.
            if (src_tick(q.internal_freq_select, ft, stk, q.post_cnt))
            begin
               n.internal_freq_select_act = q.internal_freq_select;
               n.sys_tick = 1'b1;
               n.st = ST_RUN;
            end
         end
         default:
         begin
            n.st = ST_LOAD;
         end
      endcase

      // Reported system frequency.
      n.range_err = 1'b0;
      if (is_int)
      begin
         n.freq_khz = internal_freq_select_khz(q.internal_freq_select_act);
      end
      else if (q.mode == PLL_CRYSTAL_MODE)
      begin
         if (ext_freq_khz > PLL_MAX_IN_KHZ)
         begin
            n.freq_khz = PLL_MAX_OUT_KHZ;
            n.range_err = 1'b1;
         end
         else
         begin
            n.freq_khz = {ext_freq_khz[13:0], 2'h0};
         end
      end
      else
      begin
         n.freq_khz = ext_freq_khz;
      end

      // Register writes; only the low six tune bits exist.
      if (reg_wr && (reg_addr == REG_TUNE))
      begin
         n.tune = reg_wdata[TUNE_MSB:0];
      end
      if (reg_wr && (reg_addr == REG_FREQ))
      begin
         n.internal_freq_select = reg_wdata[FREQ_MSB:0];
      end

      // Register reads; data stand for the one following cycle.
      if (reg_rd)
      begin
         case (reg_addr)
            REG_TUNE: n.rdata = {2'h0, q.tune};
            REG_FREQ: n.rdata = {5'h00, q.internal_freq_select};
            // Status shows mode and enables but no tuning-done bit.
            REG_STAT: n.rdata = {q.mode, pll_enable, fast_src_en,
                                 slow_src_en, q.st == ST_SWITCH};
            default: n.rdata = 8'h00;
         endcase
      end
   end

   // The single state register of the block.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         q <= REG_INIT;
      end
      else
      begin
         q <= n;
      end
   end

   // Quarter-rate clock for the second pin.
   sccs_div4 u_div4
   (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .tick_in(q.sys_tick),
      .run(is_clkout),
      .clk_out(div_clk)
   );

   // Mode-dependent outputs; PLL runs only in its own mode.
   assign pll_enable = (q.mode == PLL_CRYSTAL_MODE);
   assign osc_startup_req = is_xtal;
   assign pll_range_err = q.range_err;
   assign sys_tick = q.sys_tick;
   assign sysclk_freq_khz = q.freq_khz;
   assign reg_rdata = q.rdata;

   // Second pin: clock out, port bit 6, or left to the oscillator.
   assign osc_pin_out_o = is_clkout ? div_clk : (is_io6 && port_a_bit6_o);
   assign osc_pin_out_oe_b = is_clkout ? 1'b0 : (is_io6 ? port_a_bit6_oe_b : 1'b1);
   assign port_a_bit6_i = is_io6 && osc_pin_out_i;

   // First pin: port bit 7 in both internal modes.
   assign osc_pin_in_o = is_int && port_a_bit7_o;
   assign osc_pin_in_oe_b = is_int ? port_a_bit7_oe_b : 1'b1;
   assign port_a_bit7_i = is_int && osc_pin_in_i;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   // A select change while running starts a paused switch.
   sequence sw_start_s;
      (q.st == ST_RUN) && is_int && (q.internal_freq_select != q.internal_freq_select_act);
   endsequence
   sequence sw_pause_s;
      (q.st == ST_SWITCH) && !q.sys_tick;
   endsequence

   mode_load_a: assert property ((q.st == ST_LOAD) |=>
      (pll_enable == ($past(osc_mode_config) == PLL_CRYSTAL_MODE)))
      else $error("mode not loaded from configuration");
   mode_static_a: assert property ((q.st != ST_LOAD) |=> $stable(q.mode))
      else $error("mode changed after load");
   pll_mult_a: assert property ((pll_enable && (ext_freq_khz <= PLL_MAX_IN_KHZ))
      |=> (sysclk_freq_khz == 16'($past(ext_freq_khz) * 4)))
      else $error("pll frequency not four times input");
   ext_nostart_a: assert property (((q.mode == EXT_CLOCK_OUT_MODE) ||
      (q.mode == EXT_CLOCK_IO_MODE)) |-> !osc_startup_req)
      else $error("start-up requested in external clock mode");
   clkout_pin_a: assert property ((is_clkout && !q.sys_tick) |=>
      ($stable(osc_pin_out_o) && !osc_pin_out_oe_b))
      else $error("clock output pin moved without a tick");
   io6_pin_a: assert property (is_io6 |-> ((osc_pin_out_o == port_a_bit6_o) &&
      (osc_pin_out_oe_b == port_a_bit6_oe_b)))
      else $error("second pin not port bit 6");
   tune_read_a: assert property ((reg_rd && (reg_addr == REG_TUNE)) |=>
      ((reg_rdata[7:6] == 2'h0) && (reg_rdata[5:0] == $past(q.tune))))
      else $error("tune readback wrong");
   fast_off_a: assert property (!fast_src_en |=> !q.fast_tick)
      else $error("fast source ticking while disabled");
   slow_on_a: assert property ((wdt_en || is_int) |-> slow_src_en)
      else $error("slow source not enabled");
   no_runt_a: assert property (sw_start_s |=> sw_pause_s)
      else $error("clock not paused on select change");
   sw_done_a: assert property ((q.st == ST_SWITCH) |-> ##[1:700] (q.st == ST_RUN))
      else $error("select switch did not finish");
   tune_settle_a: assert property ((reg_wr && (reg_addr == REG_TUNE))
      |-> ##[1:600] (q.fast_step == fast_tgt))
      else $error("fast source did not settle");

endmodule : sccs_top

// file: tb/sccs_ext_src.sv
// Purpose: Outside clock source on the first oscillator pin.
// Assumes: Rates are whole numbers of sys_clk cycles per half period.
// Notes: Stands low while stopped, as an unpowered oscillator would.
`timescale 1ns/100ps
module sccs_ext_src
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic [3:0] half_cyc,
   output logic clk_pin
);
   logic [3:0] cnt_q; // Cycles spent in the current half period.

   // A stopped source leaves the pin low, so no stale edge can be counted.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_q <= 4'h0;
         clk_pin <= 1'b0;
      end
      else if (!run)
      begin
         // Stopping is synchronous, so only the reset stays asynchronous.
         cnt_q <= 4'h0;
         clk_pin <= 1'b0;
      end
      else if (cnt_q == half_cyc - 4'h1)
      begin
         cnt_q <= 4'h0;
         clk_pin <= ~clk_pin;
      end
      else
      begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule : sccs_ext_src

// file: tb/test_system_clock_source_select.sv
// Purpose: Self-checking bench of the clock source select block.
// Assumes: Outside rate comes from sccs_ext_src; seed fixed.
// Notes: Each mode needs its own reset, since the strap is read only once.
`timescale 1ns/100ps
module test_system_clock_source_select;
   import sccs_pkg::*;
   logic sys_clk, rst_b, run, wr, rd, pin_in, pin_out_i, b6_o, b6_oe_b, b7_o, b7_oe_b;
   logic pwrt, fscm, wdt, tse;
   logic [3:0] mode, addr;
   logic [7:0] wdata, rdata, rv, td;
   logic [15:0] ext_khz, freq;
   logic pin_in_o, pin_in_oe_b, pin_out_o, pin_out_oe_b, b6_i, b7_i, tick;
   logic pll_en, pll_err, start_req, fast_en, slow_en;
   logic [31:0] seed;
   logic [31:0] cyc = 32'h0; // Cycles since time zero, owned by the hang guard.
   int n_fail, checked, nt, nr;
   logic po_prev;

   sccs_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .osc_mode_config(mode),
      .ext_freq_khz(ext_khz), .pwrt_en(pwrt), .fscm_en(fscm), .wdt_en(wdt),
      .two_speed_en(tse), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata), .osc_pin_in_i(pin_in), .osc_pin_in_o(pin_in_o),
      .osc_pin_in_oe_b(pin_in_oe_b), .osc_pin_out_i(pin_out_i), .osc_pin_out_o(pin_out_o),
      .osc_pin_out_oe_b(pin_out_oe_b), .port_a_bit6_o(b6_o), .port_a_bit6_oe_b(b6_oe_b),
      .port_a_bit6_i(b6_i), .port_a_bit7_o(b7_o), .port_a_bit7_oe_b(b7_oe_b),
      .port_a_bit7_i(b7_i), .sys_tick(tick), .sysclk_freq_khz(freq), .pll_enable(pll_en),
      .pll_range_err(pll_err), .osc_startup_req(start_req), .fast_src_en(fast_en),
      .slow_src_en(slow_en));

   sccs_ext_src u_src (.sys_clk(sys_clk), .rst_b(rst_b), .run(run), .half_cyc(4'h3),
      .clk_pin(pin_in));

   // Free-running 10 MHz clock.
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // Next value of the repeatable random stream.
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   // Nominal rate of each internal select code, in kHz.
   function automatic logic [15:0] sel_khz(input logic [2:0] s);
      return (s == 3'h0) ? 16'h001F : (16'h1F40 >> (3'h7 - s));
   endfunction : sel_khz

   task chk_bit(input string n, input logic e, input logic s);
      checked++;
      if (s !== e)
      begin
         n_fail++;
         $display("ERROR %s expected %b seen %b", n, e, s);
      end
   endtask : chk_bit

   task chk_byte(input string n, input logic [7:0] e, input logic [7:0] s);
      checked++;
      if (s !== e)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk_byte

   task chk_word(input string n, input logic [15:0] e, input logic [15:0] s);
      checked++;
      if (s !== e)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk_word

   // One-cycle write strobe on the register port.
   task reg_write(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : reg_write

   // Read data stand only in the cycle after the strobe, so sample there.
   task reg_read(input logic [3:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge sys_clk);
   endtask : reg_read

   // The strap is loaded at the first edge after release.
   task do_reset(input logic [3:0] m);
      mode <= m;
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask : do_reset

   // Bounded wait for the reported rate; a miss shows in the compare.
   task wait_freq(input logic [15:0] e);
      for (int i = 0; i < 1000 && freq !== e; i++)
         @(posedge sys_clk);
      chk_word("sysclk_freq_khz", e, freq);
   endtask : wait_freq

   task close_out;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out

   // Hang guard, far above the thousand or so cycles the run needs.
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 32'h1;
      if (cyc == 32'h0000_9C40)
      begin
         n_fail++;
         close_out();
      end
   end

   initial
   begin
      {rst_b, run, wr, rd, pin_out_i, b6_o, b6_oe_b, b7_o, b7_oe_b} = 9'h0;
      {pwrt, fscm, wdt, tse} = 4'h0;
      mode = 4'h4;
      addr = 4'h0;
      wdata = 8'h00;
      ext_khz = 16'h0682;
      seed = 32'h4b92079f;
      n_fail = 0;
      checked = 0;
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
      // Register reset values, read-only upper bits, unmapped place.
      reg_read(REG_TUNE, rv);
      chk_byte("tune reset", 8'h00, rv);
      reg_read(REG_FREQ, rv);
      chk_byte("select reset", 8'h00, rv);
      reg_read(4'hF, rv);
      chk_byte("unmapped", 8'h00, rv);
      for (int i = 0; i < 6; i++)
      begin
         seed = xs(seed);
         td = (i == 0) ? 8'hFF : (i == 1) ? 8'hE0 : (i == 2) ? 8'h1F : seed[7:0];
         reg_write(REG_TUNE, td);
         reg_read(REG_TUNE, rv);
         chk_byte("tune", {2'b00, td[5:0]}, rv);
      end
      // Every mode and one unused code: pin roles, start-up, pll and strap readback.
      // The outside source runs, so the first pin is high when the pins are checked.
      run <= 1'b1;
      for (int m = 0; m < 11; m++)
      begin
         seed = xs(seed);
         b6_o <= seed[0];
         b7_o <= seed[1];
         pin_out_i <= seed[2];
         b6_oe_b <= seed[3];
         b7_oe_b <= seed[4];
         do_reset(m[3:0]);
         #1;
         chk_bit("pll_enable", m == 6, pll_en);
         chk_bit("startup", m <= 2 || m == 6, start_req);
         if (m == 5 || m == 7 || m == 8)
         begin
            chk_bit("pin2 oe", seed[3], pin_out_oe_b);
            chk_bit("pin2 out", seed[0], pin_out_o);
            chk_bit("bit6 in", seed[2], b6_i);
         end
         else
         begin
            chk_bit("pin2 oe", !(m == 3 || m == 4 || m == 9), pin_out_oe_b);
            chk_bit("bit6 in", 1'b0, b6_i);
         end
         chk_bit("pin1 oe", (m == 8 || m == 9) ? seed[4] : 1'b1, pin_in_oe_b);
         chk_bit("bit7 in", (m == 8 || m == 9) && pin_in, b7_i);
         if (m == 8 || m == 9)
            chk_bit("pin1 out", seed[1], pin_in_o);
         reg_read(REG_STAT, rv);
         chk_byte("mode", m[3:0], {4'h0, rv[7:4]});
         mode <= ~m[3:0];
         repeat (3) @(posedge sys_clk);
         chk_bit("pll static", m == 6, pll_en);
      end
      // Quarter-rate pin and one tick per outside period, external and RC clock-out modes.
      for (int k = 0; k < 2; k++)
      begin
         do_reset(k == 0 ? 4'h4 : 4'h3);
         run <= 1'b1;
         repeat (20) @(posedge sys_clk);
         nt = 0;
         nr = 0;
         po_prev = pin_out_o;
         repeat (240)
         begin
            @(posedge sys_clk);
            #1;
            nt += (tick === 1'b1);
            nr += (pin_out_o === 1'b1 && po_prev === 1'b0);
            po_prev = pin_out_o;
         end
         chk_bit("tick count", 1'b1, nt >= 39 && nt <= 41);
         chk_bit("quarter rate", 1'b1, nr >= 9 && nr <= 11);
         if (k == 0)
            wait_freq(ext_khz);
         run <= 1'b0;
      end
      // Slow source follows the features outside internal modes.
      for (int f = 0; f < 16; f++)
      begin
         {pwrt, fscm, wdt, tse} <= f[3:0];
         @(posedge sys_clk);
         #1;
         chk_bit("slow_src_en", f != 0, slow_en);
         chk_bit("fast_src_en", 1'b0, fast_en);
      end
      {pwrt, fscm, wdt, tse} <= 4'h0;
      // Every select code while the internal block clocks the system.
      do_reset(4'h8);
      for (int s = 7; s >= 0; s--)
      begin
         reg_write(REG_FREQ, {5'h1F, s[2:0]});
         wait_freq(sel_khz(s[2:0]));
         reg_read(REG_FREQ, rv);
         chk_byte("select", {5'h00, s[2:0]}, rv);
         chk_bit("fast_src_en", s != 0, fast_en);
         chk_bit("slow int", 1'b1, slow_en);
      end
      // Multiplier, in range and past the crystal limit.
      do_reset(4'h6);
      ext_khz <= 16'h1F40;
      @(posedge sys_clk);
      wait_freq(16'h7D00);
      chk_bit("range ok", 1'b0, pll_err);
      ext_khz <= 16'h2710;
      @(posedge sys_clk);
      wait_freq(16'h9C40);
      chk_bit("range edge", 1'b0, pll_err);
      // The output is already clamped, so give the flag time to follow.
      ext_khz <= 16'h2EE0;
      repeat (2) @(posedge sys_clk);
      wait_freq(16'h9C40);
      chk_bit("range err", 1'b1, pll_err);
      close_out();
   end
endmodule : test_system_clock_source_select
